// >>> design/state_timing_pkg.sv
// constants for the instruction state timing block
// assumes a single core clock; state costs are in core clock states
package state_timing_pkg;
    localparam int CNT_W = 4;
    localparam int STATE_W = 8;
    // per-cycle state costs
    localparam logic [1:0] COST_MEM = 2'h2;
    localparam logic [1:0] COST_INTERNAL = 2'h1;
    localparam logic [1:0] COST_PERIPH_FAST = 2'h2;
    localparam logic [1:0] COST_PERIPH_SLOW = 2'h3;
    // instruction classes with a known cycle profile
    typedef enum logic [2:0] {
        CLS_REG_OP = 3'h0,
        CLS_BRANCH = 3'h1,
        CLS_BIT_LOGIC_MEM = 3'h2,
        CLS_BIT_CLEAR_MEM = 3'h3,
        CLS_CALL_INDIRECT = 3'h4,
        CLS_EXPLICIT = 3'h7
    } instr_class_t;
    // fixed counts per class
    localparam logic [3:0] FETCH_ONE = 4'h1;
    localparam logic [3:0] FETCH_TWO = 4'h2;
    localparam logic [3:0] BYTE_ONE = 4'h1;
    localparam logic [3:0] BYTE_TWO = 4'h2;
    localparam logic [3:0] VECTOR_ONE = 4'h1;
    localparam logic [3:0] STACK_ONE = 4'h1;
    localparam logic [3:0] CNT_NONE = 4'h0;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_LAST = 2'b11
    } exec_state_t;
endpackage

// >>> design/state_weight.sv
// weighted sum of cycle counts by per-cycle state cost
// assumes counts are stable for the cycle in which they are read
`timescale 1ns/1ps
module state_weight
    import state_timing_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int SW = STATE_W
) (
    // counts
    input wire logic [CW-1:0] n_fetch,
    input wire logic [CW-1:0] n_branch,
    input wire logic [CW-1:0] n_stack,
    input wire logic [CW-1:0] n_byte,
    input wire logic [CW-1:0] n_word,
    input wire logic [CW-1:0] n_internal,
    // costs
    input wire logic [1:0] c_fetch,
    input wire logic [1:0] c_branch,
    input wire logic [1:0] c_stack,
    input wire logic [1:0] c_byte,
    input wire logic [1:0] c_word,
    input wire logic [1:0] c_internal,
    // result
    output logic [SW-1:0] total
);
    function automatic logic [SW-1:0] wt(input logic [CW-1:0] n, input logic [1:0] c);
        wt = SW'(n) * SW'(c);
    endfunction
    assign total = SW'(wt(n_fetch, c_fetch) + wt(n_branch, c_branch) + wt(n_stack, c_stack)
                 + wt(n_byte, c_byte) + wt(n_word, c_word) + wt(n_internal, c_internal));
endmodule

// >>> design/instruction_state_timing.sv
// instruction state timing: total states per instruction and a busy window
// assumes the decoder presents a class or explicit counts with a one-cycle start
// assumes start and its qualifiers come from logic on ref_clk, so no synchroniser
// Summary of operation
// - The total states are the sum over six cycle types of count times per-cycle cost.
// - An instruction fetch from on-chip memory costs two states.
// - An internal operation cycle always costs one state.
// - A byte access to a peripheral costs two or three states by which module is hit.
// - Vector reads and stack cycles to on-chip memory cost two states each.
// - Register ops take one fetch, branches two, bit logic on memory two plus one byte, bit clear two plus two bytes.
`timescale 1ns/1ps
module instruction_state_timing
    import state_timing_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int SW = STATE_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // instruction request
    input wire logic start,
    input wire instr_class_t instr_class,
    input wire logic byte_to_periph,
    input wire logic periph_slow,
    // explicit counts, used with the explicit class; x_word counts only while byte_to_periph is low
    input wire logic [CW-1:0] x_fetch,
    input wire logic [CW-1:0] x_branch,
    input wire logic [CW-1:0] x_stack,
    input wire logic [CW-1:0] x_byte,
    input wire logic [CW-1:0] x_word,
    input wire logic [CW-1:0] x_internal,
    // results
    output logic [SW-1:0] exec_states,
    output logic busy,
    output logic done
);
    logic [CW-1:0] n_fetch, n_branch, n_stack, n_byte, n_word, n_internal;
    logic [1:0] c_byte;
    logic [SW-1:0] next_total;
    logic [SW-1:0] remaining;
    exec_state_t state;
    logic accept;

    // ----------------------------------------
    // local constants
    // ----------------------------------------
    // shortest window: even a zero total holds busy one state
    localparam logic [SW-1:0] MIN_STATES = SW'(1);

    // ----------------------------------------
    // cycle profile per class
    // ----------------------------------------
    always_comb begin
        n_fetch = CNT_NONE;
        n_branch = CNT_NONE;
        n_stack = CNT_NONE;
        n_byte = CNT_NONE;
        n_word = CNT_NONE;
        n_internal = CNT_NONE;
        case (instr_class)
            CLS_REG_OP: begin
                n_fetch = FETCH_ONE;
            end
            CLS_BRANCH: begin
                n_fetch = FETCH_TWO;
            end
            CLS_BIT_LOGIC_MEM: begin
                n_fetch = FETCH_TWO;
                n_byte = BYTE_ONE;
            end
            CLS_BIT_CLEAR_MEM: begin
                n_fetch = FETCH_TWO;
                n_byte = BYTE_TWO;
            end
            // indirect call, one vector, one push
            CLS_CALL_INDIRECT: begin
                n_fetch = FETCH_TWO;
                n_branch = VECTOR_ONE;
                n_stack = STACK_ONE;
            end
            CLS_EXPLICIT: begin
                n_fetch = x_fetch;
                n_branch = x_branch;
                n_stack = x_stack;
                n_byte = x_byte;
                n_word = byte_to_periph ? CNT_NONE : x_word;
                n_internal = x_internal;
            end
            // unused class codes fall back to the shortest profile
            default: begin
                n_fetch = FETCH_ONE;
            end
        endcase
    end

    // limitation: which module is slow is told from outside, not decoded here
    // peripheral byte cost by module speed
    always_comb begin
        c_byte = COST_MEM;
        if (byte_to_periph) begin
            c_byte = periph_slow ? COST_PERIPH_SLOW : COST_PERIPH_FAST;
        end
    end

    // ----------------------------------------
    // weighting
    // ----------------------------------------
    // fixed memory and internal costs
    state_weight #(.CW(CW), .SW(SW)) u_weight (
        .n_fetch(n_fetch),
        .n_branch(n_branch),
        .n_stack(n_stack),
        .n_byte(n_byte),
        .n_word(n_word),
        .n_internal(n_internal),
        .c_fetch(COST_MEM),
        .c_branch(COST_MEM),
        .c_stack(COST_MEM),
        .c_byte(c_byte),
        .c_word(COST_MEM),
        .c_internal(COST_INTERNAL),
        .total(next_total)
    );

    // ----------------------------------------
    // request acceptance
    // ----------------------------------------
    // a request is only seen while idle; one raised while busy is dropped
    assign accept = start && (state == ST_IDLE);

    // ----------------------------------------
    // latch result
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exec_states <= '0;
        end else if (accept) begin
            exec_states <= next_total;
        end
    end

    // ----------------------------------------
    // execution sequence
    // ----------------------------------------
    // walk the counted states
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    // a zero total still finishes in one state
                    if (start) begin
                        if (next_total <= MIN_STATES) begin
                            state <= ST_LAST;
                        end else begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (remaining == MIN_STATES) begin
                        state <= ST_LAST;
                    end
                end
                ST_LAST: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // states left
    // ----------------------------------------
    // counts down to the last state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            remaining <= '0;
        end else if (accept) begin
            // wraps for a zero total, but that path never reads it
            remaining <= next_total - MIN_STATES;
        end else if (state == ST_RUN) begin
            remaining <= remaining - MIN_STATES;
        end
    end

    // ----------------------------------------
    // busy window
    // ----------------------------------------
    // busy for exactly the total states, or for one state when the total is zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= accept || (state == ST_RUN);
        end
    end

    // ----------------------------------------
    // completion pulse
    // ----------------------------------------
    // one cycle, in the cycle busy drops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= (state == ST_LAST);
        end
    end
endmodule

// >>> testbench/instruction_state_timing_properties.sv
// checker: totals per class, busy length, done pulse
// assumes it is bound to the top module and sees its ports
`timescale 1ns/1ps
module instruction_state_timing_properties
    import state_timing_pkg::*;
#(
    parameter int SW = STATE_W
) (
    // clock and request
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire instr_class_t instr_class,
    input wire logic byte_to_periph,
    input wire logic periph_slow,
    // results
    input wire logic [SW-1:0] exec_states,
    input wire logic busy,
    input wire logic done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic take;
    logic [SW-1:0] bytec, cls_exp, cnt;
    assign take = start && !busy;
    assign bytec = (byte_to_periph && periph_slow) ? SW'(2'h3) : SW'(2'h2);
    always_comb begin
        case (instr_class)
            CLS_BRANCH: cls_exp = SW'(4'h4);
            CLS_BIT_LOGIC_MEM: cls_exp = SW'(4'h4) + bytec;
            CLS_BIT_CLEAR_MEM: cls_exp = SW'(4'h4) + bytec + bytec;
            CLS_CALL_INDIRECT: cls_exp = SW'(4'h8);
            default: cls_exp = SW'(4'h2);
        endcase
    end
    // busy cycles so far; cleared while idle
    always_ff @(posedge ref_clk) begin
        if (rst) cnt <= '0;
        else cnt <= busy ? cnt + 1'b1 : '0;
    end
    chk_class_total: assert property (
        take && instr_class != CLS_EXPLICIT |=> exec_states == $past(cls_exp))
        else $error("class total wrong");
    chk_slow_clear: assert property (
        take && instr_class == CLS_BIT_CLEAR_MEM && byte_to_periph && periph_slow
        |=> exec_states == SW'(8'h0A)) else $error("slow peripheral total wrong");
    chk_busy_start: assert property (take |=> busy) else $error("busy not raised");
    chk_busy_length: assert property (
        $fell(busy) |-> cnt == ((exec_states == '0) ? SW'(1'h1) : exec_states))
        else $error("busy length wrong");
    chk_done_fall: assert property (done == $fell(busy)) else $error("done misplaced");
    chk_done_single: assert property (done |=> !done) else $error("done too long");
    chk_hold_total: assert property (busy |=> $stable(exec_states))
        else $error("total changed while busy");
    cover property (take && instr_class == CLS_EXPLICIT);
    cover property (take && byte_to_periph && periph_slow);
    cover property (done && start);
endmodule

bind instruction_state_timing instruction_state_timing_properties #(.SW(SW)) i_props (
    .ref_clk, .rst, .start, .instr_class, .byte_to_periph, .periph_slow,
    .exec_states, .busy, .done);

// >>> testbench/instruction_state_timing_test.sv
// bench: class totals, peripheral costs, explicit counts, refusal
// assumes the checker binds itself to the design
`timescale 1ns/1ps
module instruction_state_timing_test
    import state_timing_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0, byte_to_periph = 1'b0, periph_slow = 1'b0;
    instr_class_t instr_class = CLS_REG_OP;
    logic [3:0] x_fetch = 4'h0, x_branch = 4'h0, x_stack = 4'h0;
    logic [3:0] x_byte = 4'h0, x_word = 4'h0, x_internal = 4'h0;
    logic [7:0] exec_states;
    logic busy, done;
    int err_total = 0, checks_done = 0, cycles = 0;
    instruction_state_timing i_dut (.ref_clk, .rst, .start, .instr_class, .byte_to_periph,
        .periph_slow, .x_fetch, .x_branch, .x_stack, .x_byte, .x_word, .x_internal,
        .exec_states, .busy, .done);
    initial forever #4 ref_clk = ~ref_clk;
    // a mismatch: count it and say where
    task automatic note_fail(input string msg);
        err_total++;
        $display("CHECK FAILED %0t %s", $time, msg);
    endtask
    task automatic print_verdict();
        if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one request, then total and busy length against the expectation
    task automatic run(input instr_class_t c, input logic p, input logic s, input logic [7:0] e);
        int n = 0;
        @(posedge ref_clk);
        start <= 1'b1;
        instr_class <= c;
        byte_to_periph <= p;
        periph_slow <= s;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        checks_done++;
        if (exec_states !== e) note_fail("total");
        while (busy === 1'b1 && n < 300) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
        checks_done++;
        if (n != ((e == 8'h00) ? 1 : e) || done !== 1'b1) note_fail("busy length");
    endtask
    task automatic t_classes();
        logic [7:0] e [6] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h08, 8'h02};
        for (int k = 0; k < 6; k++) run(instr_class_t'(k), 1'b0, 1'b0, e[k]);
    endtask
    task automatic t_periph();
        run(CLS_BIT_LOGIC_MEM, 1'b1, 1'b0, 8'h06);
        run(CLS_BIT_LOGIC_MEM, 1'b1, 1'b1, 8'h07);
        run(CLS_BIT_CLEAR_MEM, 1'b1, 1'b1, 8'h0A);
        run(CLS_CALL_INDIRECT, 1'b1, 1'b1, 8'h08);
    endtask
    task automatic t_explicit();
        @(posedge ref_clk);
        {x_fetch, x_branch, x_stack, x_byte, x_word, x_internal} <= {6{4'h1}};
        run(CLS_EXPLICIT, 1'b0, 1'b0, 8'h0B);
        run(CLS_EXPLICIT, 1'b1, 1'b1, 8'h0A);
        @(posedge ref_clk);
        {x_fetch, x_branch, x_stack, x_byte, x_word, x_internal} <= {20'h0, 4'h3};
        run(CLS_EXPLICIT, 1'b1, 1'b0, 8'h03);
        @(posedge ref_clk);
        x_internal <= 4'h0;
        run(CLS_EXPLICIT, 1'b0, 1'b0, 8'h00);
    endtask
    // start held high: refused while busy, taken in the done cycle
    task automatic t_refuse();
        @(posedge ref_clk);
        start <= 1'b1;
        instr_class <= CLS_REG_OP;
        @(posedge ref_clk);
        instr_class <= CLS_CALL_INDIRECT;
        @(posedge ref_clk);
        #1;
        checks_done++;
        if (exec_states !== 8'h02 || busy !== 1'b1) note_fail("refused");
        @(posedge ref_clk);
        #1;
        checks_done++;
        if (done !== 1'b1) note_fail("done");
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        checks_done++;
        if (exec_states !== 8'h08) note_fail("back to back");
        repeat (9) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_classes();
        t_periph();
        t_explicit();
        t_refuse();
        print_verdict();
    end
endmodule
